// ===== common/sese_defs.svh
/*
  Bit positions, reset values and error codes of the status event reporting block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SESE_DEFS_SVH
`define SESE_DEFS_SVH

// event status latch bit positions
`define SESE_EVL_OPC        0
`define SESE_EVL_QUERY      2
`define SESE_EVL_DEVICE     3
`define SESE_EVL_EXEC       4
`define SESE_EVL_CMD        5
`define SESE_EVL_USER       6
`define SESE_EVL_PON        7

// operation status bit positions
`define SESE_OPS_SETTING    1
`define SESE_OPS_MEASURING  4
`define SESE_OPS_WAIT_TRIG  5
`define SESE_OPS_BATTERY    8
`define SESE_OPS_LIMIT      9

// status summary byte bit positions
`define SESE_SSB_ERRQ       2
`define SESE_SSB_QUES       3
`define SESE_SSB_MAV        4
`define SESE_SSB_ESB        5
`define SESE_SSB_MSS        6
`define SESE_SSB_OPER       7

// reset values
`define SESE_PPM_RESET      8'h00
`define SESE_EVM_RESET      8'h00
`define SESE_OPS_EN_RESET   16'h0000
`define SESE_OPS_PTR_RESET  16'hFFFF
`define SESE_OPS_NTR_RESET  16'h0000

// error queue numbers, two's complement
`define SESE_ERR_CMD        16'hFF9C
`define SESE_ERR_EXEC       16'hFF38

`endif

// ===== common/sese_pkg.sv
/*
  Types of the status event reporting block: command codes and the completion tracker states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sese_pkg;

  typedef enum logic [3:0] {
    SESE_CMD_PRE_WR      = 4'h0,
    SESE_CMD_PRE_RD      = 4'h1,
    SESE_CMD_PPF_RD      = 4'h2,
    SESE_CMD_EVL_RD      = 4'h3,
    SESE_CMD_EVM_WR      = 4'h4,
    SESE_CMD_EVM_RD      = 4'h5,
    SESE_CMD_OPC         = 4'h6,
    SESE_CMD_OPS_COND_RD = 4'h7,
    SESE_CMD_OPS_EV_RD   = 4'h8,
    SESE_CMD_OPS_EN_WR   = 4'h9,
    SESE_CMD_OPS_EN_RD   = 4'hA,
    SESE_CMD_OPS_PTR_WR  = 4'hB,
    SESE_CMD_OPS_NTR_WR  = 4'hC,
    SESE_CMD_OTHER       = 4'hD
  } sese_cmd_type;

  typedef enum logic [1:0] {
    SESE_OPC_IDLE = 2'b01,
    SESE_OPC_WAIT = 2'b10
  } sese_opc_type;

endpackage : sese_pkg

// ===== common/sese_ev_if.sv
/*
  Carrier between an event latch and its user: set, read-clear, enable, contents, sum.
  Assumes both sides share the block clock.
*/
`timescale 1ns/1ps
interface sese_ev_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] rd_clr;
  logic [W-1:0] en;
  logic [W-1:0] latch;
  logic         sum;

  modport store (input set, input rd_clr, input en, output latch, output sum);
  modport user  (output set, output rd_clr, output en, input latch, input sum);
endinterface : sese_ev_if

// ===== design/sese_evlatch.sv
/*
  Sticky event latch with enable mask and summary bit.
  Assumes set and rd_clr are single-cycle vectors from the user.
*/
`timescale 1ns/1ps
module sese_evlatch #(
  parameter int W = 8
) (
  input  wire logic   i_clk,
  input  wire logic   i_reset,
  input  wire logic   i_ce,
  sese_ev_if.store    ev
);
  logic [W-1:0] latch_q;

  // set beats a clear arriving in the same cycle so no event is lost
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      latch_q <= '0;
    else if (i_ce)
      latch_q <= (latch_q & ~ev.rd_clr) | ev.set;

  assign ev.latch = latch_q;
  assign ev.sum   = |(latch_q & ev.en);

  set_wins_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_ce && (ev.set != '0)) |=> ((ev.latch & $past(ev.set)) == $past(ev.set)))
    else $error("event lost against clear");
endmodule : sese_evlatch

// ===== design/sese_ppoll.sv
/*
  Parallel poll mask register and registered summary flag.
  Assumes the status summary byte is stable in the block clock domain.
*/
`timescale 1ns/1ps
`include "sese_defs.svh"
module sese_ppoll (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_ssb,
  output logic      [7:0] o_mask,
  output logic            o_flag
);
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      o_mask <= `SESE_PPM_RESET;
    else if (i_ce && i_wr)
      o_mask <= i_wdata;

  // all eight bits count here, the summary bit too
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      o_flag <= 1'b0;
    else if (i_ce)
      o_flag <= |(i_ssb & o_mask);
endmodule : sese_ppoll

// ===== design/sese_status.sv
/*
  Status event reporting: event status latch and enable, operation status condition,
  transition filters and event part, status summary byte, parallel poll flag and
  the command/response port that a bus message decoder drives.
  Assumes commands arrive as one-cycle strobes from the decoder, all inputs are
  synchronous to i_clk, and i_busy is high while earlier commands still execute.
*/
`timescale 1ns/1ps
`include "sese_defs.svh"

// Functional notes
// - mask summary byte with poll mask, bit 6 included
// - poll flag is OR of masked bits
// - poll flag returned on poll and query
// - poll mask stored and read back unchanged
// - event latch query returns its contents
// - event enable mask stored and read back
// - completion bit only after earlier commands finish
// - query error on unasked read or unread response
// - device fault sets bit 3, queues error; not queued if a command or execution error comes in the same cycle
// - execution error sets bit 4, queues error; not queued if a command error comes in the same cycle
// - command error sets bit 5, queues error
// - manual takeover key sets bit 6
// - power-on sets bit 7
// - condition live, event latched, both readable
// - bit 1 while sensor initializing
// - bit 4 while measuring
// - bit 5 while waiting for trigger
// - bit 8 while battery powered
// - bit 9 during limit check
// - summary bit 5 from enabled event latch
// - summary bit 7 from enabled operation events
module sese_status (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  input  wire logic        i_cmd_valid,
  input  wire logic [3:0]  i_cmd_code,
  input  wire logic [15:0] i_cmd_data,
  input  wire logic        i_talk_read,
  input  wire logic        i_busy,
  input  wire logic        i_ppoll,
  input  wire logic        i_dev_fault,
  input  wire logic [15:0] i_dev_code,
  input  wire logic        i_exec_fail,
  input  wire logic        i_manual_key,
  input  wire logic        i_sensor_init,
  input  wire logic        i_measuring,
  input  wire logic        i_wait_trigger,
  input  wire logic        i_battery_powered,
  input  wire logic        i_limit_check_active,
  input  wire logic        i_err_queue_nonempty,
  input  wire logic        i_ques_summary,
  input  wire logic        i_mss,
  output logic             o_rsp_valid,
  output logic      [15:0] o_rsp_data,
  output logic             o_ppoll_valid,
  output logic             o_parallel_poll_summary_flag,
  output logic             o_err_push,
  output logic      [15:0] o_err_code,
  output logic      [7:0]  o_status_summary_byte
);

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  sese_pkg::sese_cmd_type cmd;
  logic                   cmd_legal;
  logic                   cmd_query;
  logic                   take;

  assign cmd  = sese_pkg::sese_cmd_type'(i_cmd_code);
  assign take = i_ce && i_cmd_valid;

  always_comb
  begin
    cmd_legal = 1'b1;
    cmd_query = 1'b0;
    unique case (cmd)
      sese_pkg::SESE_CMD_PRE_RD, sese_pkg::SESE_CMD_PPF_RD, sese_pkg::SESE_CMD_EVL_RD,
      sese_pkg::SESE_CMD_EVM_RD, sese_pkg::SESE_CMD_OPS_COND_RD,
      sese_pkg::SESE_CMD_OPS_EV_RD, sese_pkg::SESE_CMD_OPS_EN_RD:
        cmd_query = 1'b1;
      sese_pkg::SESE_CMD_PRE_WR, sese_pkg::SESE_CMD_EVM_WR, sese_pkg::SESE_CMD_OPC,
      sese_pkg::SESE_CMD_OPS_EN_WR, sese_pkg::SESE_CMD_OPS_PTR_WR,
      sese_pkg::SESE_CMD_OPS_NTR_WR, sese_pkg::SESE_CMD_OTHER:
        cmd_query = 1'b0;
      default:
        cmd_legal = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable and filter registers

  logic [7:0]  evm_q;
  logic [15:0] ops_en_q;
  logic [15:0] ops_ptr_q;
  logic [15:0] ops_ntr_q;

  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      evm_q <= `SESE_EVM_RESET;
    else if (take && cmd == sese_pkg::SESE_CMD_EVM_WR)
      evm_q <= i_cmd_data[7:0];

  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
    begin
      ops_en_q  <= `SESE_OPS_EN_RESET;
      ops_ptr_q <= `SESE_OPS_PTR_RESET;
      ops_ntr_q <= `SESE_OPS_NTR_RESET;
    end
    else if (take)
    begin
      if (cmd == sese_pkg::SESE_CMD_OPS_EN_WR)
        ops_en_q <= i_cmd_data;
      if (cmd == sese_pkg::SESE_CMD_OPS_PTR_WR)
        ops_ptr_q <= i_cmd_data;
      if (cmd == sese_pkg::SESE_CMD_OPS_NTR_WR)
        ops_ntr_q <= i_cmd_data;
    end

  //////////////////////////////////////////////////////////////////////////////
  // operation status condition and transitions

  logic [15:0] ops_cond;
  logic [15:0] ops_cond_q;

  always_comb
  begin
    ops_cond                      = 16'h0000;
    ops_cond[`SESE_OPS_SETTING]   = i_sensor_init;
    ops_cond[`SESE_OPS_MEASURING] = i_measuring;
    ops_cond[`SESE_OPS_WAIT_TRIG] = i_wait_trigger;
    ops_cond[`SESE_OPS_BATTERY]   = i_battery_powered;
    ops_cond[`SESE_OPS_LIMIT]     = i_limit_check_active;
  end

  // previous condition starts at zero so activity present at reset counts as a rise
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      ops_cond_q <= 16'h0000;
    else if (i_ce)
      ops_cond_q <= ops_cond;

  sese_ev_if #(.W(16)) ops_ev ();

  assign ops_ev.set = (ops_cond & ~ops_cond_q & ops_ptr_q)
                    | (~ops_cond & ops_cond_q & ops_ntr_q);
  assign ops_ev.en  = ops_en_q;
  assign ops_ev.rd_clr = (take && cmd == sese_pkg::SESE_CMD_OPS_EV_RD) ?
                         ops_ev.latch : 16'h0000;

  sese_evlatch #(.W(16)) u_ops_latch (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .ev      (ops_ev)
  );

  //////////////////////////////////////////////////////////////////////////////
  // completion tracker

  sese_pkg::sese_opc_type opc_q;
  logic                   opc_done;

  assign opc_done = (opc_q == sese_pkg::SESE_OPC_WAIT) && !i_busy;

  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      opc_q <= sese_pkg::SESE_OPC_IDLE;
    else if (i_ce)
    begin
      unique case (opc_q)
        sese_pkg::SESE_OPC_IDLE:
          if (take && cmd == sese_pkg::SESE_CMD_OPC)
            opc_q <= sese_pkg::SESE_OPC_WAIT;
        sese_pkg::SESE_OPC_WAIT:
          if (!i_busy)
            opc_q <= sese_pkg::SESE_OPC_IDLE;
        default:
          opc_q <= sese_pkg::SESE_OPC_IDLE;
      endcase
    end

  //////////////////////////////////////////////////////////////////////////////
  // response bookkeeping and query errors

  logic pend_q;
  logic query_err;
  logic pon_q;

  assign query_err = i_ce && ((i_talk_read && !pend_q) || (i_cmd_valid && pend_q));

  // a new command discards an unread answer
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      pend_q <= 1'b0;
    else if (take)
      pend_q <= cmd_legal && cmd_query;
    else if (i_ce && i_talk_read)
      pend_q <= 1'b0;

  // first enabled cycle after reset stands for switch-on
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      pon_q <= 1'b0;
    else if (i_ce)
      pon_q <= 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // event status latch

  sese_ev_if #(.W(8)) evl_ev ();
  logic [7:0]         evl_set;

  always_comb
  begin
    evl_set                   = 8'h00;
    evl_set[`SESE_EVL_OPC]    = opc_done;
    evl_set[`SESE_EVL_QUERY]  = query_err;
    evl_set[`SESE_EVL_DEVICE] = i_dev_fault;
    evl_set[`SESE_EVL_EXEC]   = i_exec_fail;
    evl_set[`SESE_EVL_CMD]    = take && !cmd_legal;
    evl_set[`SESE_EVL_USER]   = i_manual_key;
    evl_set[`SESE_EVL_PON]    = !pon_q;
  end

  assign evl_ev.set    = evl_set;
  assign evl_ev.en     = evm_q;
  assign evl_ev.rd_clr = (take && cmd == sese_pkg::SESE_CMD_EVL_RD) ?
                         evl_ev.latch : 8'h00;

  sese_evlatch #(.W(8)) u_evl_latch (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .ev      (evl_ev)
  );

  //////////////////////////////////////////////////////////////////////////////
  // error queue entries, one per cycle: command over execution over device

  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
    begin
      o_err_push <= 1'b0;
      o_err_code <= 16'h0000;
    end
    else if (i_ce)
    begin
      o_err_push <= (take && !cmd_legal) || i_exec_fail || i_dev_fault;
      if (take && !cmd_legal)
        o_err_code <= `SESE_ERR_CMD;
      else if (i_exec_fail)
        o_err_code <= `SESE_ERR_EXEC;
      else if (i_dev_fault)
        o_err_code <= i_dev_code;
    end

  //////////////////////////////////////////////////////////////////////////////
  // status summary byte and parallel poll

  logic [7:0] ssb;
  logic [7:0] ppm;
  logic       ppf;

  always_comb
  begin
    ssb                 = 8'h00;
    ssb[`SESE_SSB_ERRQ] = i_err_queue_nonempty;
    ssb[`SESE_SSB_QUES] = i_ques_summary;
    ssb[`SESE_SSB_MAV]  = pend_q;
    ssb[`SESE_SSB_ESB]  = evl_ev.sum;
    ssb[`SESE_SSB_MSS]  = i_mss;
    ssb[`SESE_SSB_OPER] = ops_ev.sum;
  end

  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      o_status_summary_byte <= 8'h00;
    else if (i_ce)
      o_status_summary_byte <= ssb;

  sese_ppoll u_ppoll (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_wr    (take && cmd == sese_pkg::SESE_CMD_PRE_WR),
    .i_wdata (i_cmd_data[7:0]),
    .i_ssb   (ssb),
    .o_mask  (ppm),
    .o_flag  (ppf)
  );

  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
    begin
      o_ppoll_valid                <= 1'b0;
      o_parallel_poll_summary_flag <= 1'b0;
    end
    else if (i_ce)
    begin
      o_ppoll_valid <= i_ppoll;
      if (i_ppoll)
        o_parallel_poll_summary_flag <= ppf;
    end

  //////////////////////////////////////////////////////////////////////////////
  // query answers

  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= 16'h0000;
    end
    else if (i_ce)
    begin
      o_rsp_valid <= take && cmd_legal && cmd_query;
      if (take)
      begin
        unique case (cmd)
          sese_pkg::SESE_CMD_PRE_RD:      o_rsp_data <= {8'h00, ppm};
          sese_pkg::SESE_CMD_PPF_RD:      o_rsp_data <= {15'h0000, ppf};
          sese_pkg::SESE_CMD_EVL_RD:      o_rsp_data <= {8'h00, evl_ev.latch};
          sese_pkg::SESE_CMD_EVM_RD:      o_rsp_data <= {8'h00, evm_q};
          sese_pkg::SESE_CMD_OPS_COND_RD: o_rsp_data <= ops_cond_q;
          sese_pkg::SESE_CMD_OPS_EV_RD:   o_rsp_data <= ops_ev.latch;
          sese_pkg::SESE_CMD_OPS_EN_RD:   o_rsp_data <= ops_en_q;
          default:                        o_rsp_data <= o_rsp_data;
        endcase
      end
    end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  ppoll_mask_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce |=> (ppf == |($past(ssb) & $past(ppm))))
    else $error("poll flag not masked or of summary byte");

  ppf_query_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && cmd == sese_pkg::SESE_CMD_PPF_RD) |=> (o_rsp_valid && o_rsp_data[0] == $past(ppf)))
    else $error("flag query answer wrong");

  pre_readback_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && cmd == sese_pkg::SESE_CMD_PRE_WR) ##1 !take
    ##1 (take && cmd == sese_pkg::SESE_CMD_PRE_RD)
    |=> (o_rsp_data[7:0] == $past(i_cmd_data[7:0], 3)))
    else $error("poll mask not read back");

  latch_query_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && cmd == sese_pkg::SESE_CMD_EVL_RD) |=> (o_rsp_data[7:0] == $past(evl_ev.latch)))
    else $error("event latch answer wrong");

  enable_readback_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && cmd == sese_pkg::SESE_CMD_EVM_RD) |=> (o_rsp_data[7:0] == $past(evm_q)))
    else $error("event enable answer wrong");

  opc_wait_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_ce && i_busy) |=> !$rose(evl_ev.latch[`SESE_EVL_OPC]))
    else $error("completion set while busy");

  query_err_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_ce && i_talk_read && !pend_q) |=> evl_ev.latch[`SESE_EVL_QUERY])
    else $error("unasked read not flagged");

  cmd_err_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && !cmd_legal) |=> (o_err_push && o_err_code == `SESE_ERR_CMD
                              && evl_ev.latch[`SESE_EVL_CMD]))
    else $error("command error not reported");

  esb_sum_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce |=> (o_status_summary_byte[`SESE_SSB_ESB] == $past(|(evl_ev.latch & evm_q))))
    else $error("event summary bit wrong");

  oper_rise_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_ce && ops_cond_q == 16'h0000 && ops_cond[`SESE_OPS_MEASURING]
     && ops_ptr_q[`SESE_OPS_MEASURING]) |=> ops_ev.latch[`SESE_OPS_MEASURING])
    else $error("rising condition not latched");

  power_on_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_ce && !pon_q) |=> evl_ev.latch[`SESE_EVL_PON])
    else $error("power-on bit not set");

  opc_seen_c:   cover property (@(posedge i_clk) disable iff (i_reset) evl_set[`SESE_EVL_OPC]);
  ppoll_hit_c:  cover property (@(posedge i_clk) disable iff (i_reset)
    i_ppoll ##1 o_parallel_poll_summary_flag);
  oper_sum_c:   cover property (@(posedge i_clk) disable iff (i_reset) ssb[`SESE_SSB_OPER]);
  query_err_c:  cover property (@(posedge i_clk) disable iff (i_reset) query_err);

endmodule : sese_status

// ===== bench/sese_ctrl_model.sv
/*
  Remote controller model: issues commands, fetches answers and runs parallel polls.
  Assumes the status block samples on the rising edge of i_clk.
*/
`timescale 1ns/1ps
module sese_ctrl_model (
  input  wire logic        i_clk,
  input  wire logic        i_rsp_valid,
  input  wire logic [15:0] i_rsp_data,
  input  wire logic        i_ppoll_valid,
  input  wire logic        i_flag,
  output logic             o_cmd_valid,
  output logic      [3:0]  o_cmd_code,
  output logic      [15:0] o_cmd_data,
  output logic             o_talk_read,
  output logic             o_ppoll
);
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = 4'h0;
    o_cmd_data  = 16'h0000;
    o_talk_read = 1'b0;
    o_ppoll     = 1'b0;
  end

  // one command per call; mask writes and reads go through here too
  task automatic send(input logic [3:0] c, input logic [15:0] d);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_code  <= c;
    o_cmd_data  <= d;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    // released data must not look like a held value
    o_cmd_data  <= ~d;
  endtask : send

  task automatic fetch();
    @(posedge i_clk);
    o_talk_read <= 1'b1;
    @(posedge i_clk);
    o_talk_read <= 1'b0;
  endtask : fetch

  task automatic query(input logic [3:0] c, output logic [15:0] d, output logic v);
    send(c, 16'h0000);
    #1;
    d = i_rsp_data;
    v = i_rsp_valid;
    fetch();
  endtask : query

  task automatic poll(output logic v, output logic f);
    @(posedge i_clk);
    o_ppoll <= 1'b1;
    @(posedge i_clk);
    o_ppoll <= 1'b0;
    #1;
    v = i_ppoll_valid;
    f = i_flag;
  endtask : poll
endmodule : sese_ctrl_model

// ===== bench/status_event_reporting_bench.sv
/*
  Self-checking bench of the status event reporting block.
  Assumes the controller model file is compiled before this one.
*/
`timescale 1ns/1ps
module status_event_reporting_bench;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        busy;
  logic        dev_fault;
  logic [15:0] dev_code;
  logic        exec_fail;
  logic        manual;
  logic [4:0]  cond;
  logic        errq;
  logic        ques;
  logic        mss;
  logic        cmd_valid;
  logic [3:0]  cmd_code;
  logic [15:0] cmd_data;
  logic        talk_read;
  logic        ppoll;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        ppoll_valid;
  logic        flag;
  logic        err_push;
  logic [15:0] err_code;
  logic [7:0]  ssb;
  logic [15:0] d;
  logic        v;
  logic        f;
  int          bad_count;
  int          n_tests;
  int          pos [5] = '{1, 4, 5, 8, 9};
  logic [7:0]  vals [4] = '{8'h00, 8'hFF, 8'h40, 8'hA5};

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {busy, dev_fault, exec_fail, manual, errq, ques, mss} = 7'h00;
    dev_code = 16'h0000;
    cond = 5'h00;
    bad_count = 0;
    n_tests = 0;
  end

  always #10 clk = ~clk;

  sese_ctrl_model ctrl (.i_clk(clk), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
    .i_ppoll_valid(ppoll_valid), .i_flag(flag), .o_cmd_valid(cmd_valid),
    .o_cmd_code(cmd_code), .o_cmd_data(cmd_data), .o_talk_read(talk_read), .o_ppoll(ppoll));

  sese_status DUT (.i_clk(clk), .i_reset(rst), .i_ce(ce), .i_cmd_valid(cmd_valid),
    .i_cmd_code(cmd_code), .i_cmd_data(cmd_data), .i_talk_read(talk_read), .i_busy(busy),
    .i_ppoll(ppoll), .i_dev_fault(dev_fault), .i_dev_code(dev_code),
    .i_exec_fail(exec_fail), .i_manual_key(manual), .i_sensor_init(cond[0]),
    .i_measuring(cond[1]), .i_wait_trigger(cond[2]), .i_battery_powered(cond[3]),
    .i_limit_check_active(cond[4]), .i_err_queue_nonempty(errq), .i_ques_summary(ques),
    .i_mss(mss), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_ppoll_valid(ppoll_valid), .o_parallel_poll_summary_flag(flag),
    .o_err_push(err_push), .o_err_code(err_code), .o_status_summary_byte(ssb));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic q(input logic [3:0] c, input logic [15:0] exp);
    ctrl.query(c, d, v);
    check(v, 1'b1);
    check(d, exp);
  endtask : q

  task automatic pulse(input int k, input logic [15:0] code);
    @(posedge clk);
    dev_code <= code;
    case (k)
      0: dev_fault <= 1'b1;
      1: exec_fail <= 1'b1;
      default: manual <= 1'b1;
    endcase
    @(posedge clk);
    {dev_fault, exec_fail, manual} <= 3'b000;
    #1;
    if (k < 2)
    begin
      check(err_push, 1'b1);
      check(err_code, code);
    end
  endtask : pulse

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0080);
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0000);
    $display("test power_on done");
    foreach (vals[i])
    begin
      ctrl.send(sese_pkg::SESE_CMD_PRE_WR, {8'h00, vals[i]});
      q(sese_pkg::SESE_CMD_PRE_RD, {8'h00, vals[i]});
      ctrl.send(sese_pkg::SESE_CMD_EVM_WR, {8'h00, vals[i]});
      q(sese_pkg::SESE_CMD_EVM_RD, {8'h00, vals[i]});
    end
    $display("test masks done");
    ctrl.send(sese_pkg::SESE_CMD_PRE_WR, 16'h0040);
    mss <= 1'b1;
    repeat (4) @(posedge clk);
    q(sese_pkg::SESE_CMD_PPF_RD, 16'h0001);
    ctrl.poll(v, f);
    check({v, f}, 2'b11);
    mss <= 1'b0;
    {errq, ques} <= 2'b11;
    repeat (4) @(posedge clk);
    check(ssb[3:2], 2'b11);
    ctrl.poll(v, f);
    check({v, f}, 2'b10);
    ctrl.send(sese_pkg::SESE_CMD_PRE_WR, 16'h0008);
    repeat (3) @(posedge clk);
    q(sese_pkg::SESE_CMD_PPF_RD, 16'h0001);
    $display("test poll done");
    pulse(0, 16'hFED4);
    pulse(1, 16'hFF38);
    pulse(2, 16'h0000);
    ctrl.send(4'hE, 16'h0000);
    #1;
    check({err_push, err_code}, {1'b1, 16'hFF9C});
    ctrl.send(sese_pkg::SESE_CMD_EVM_WR, 16'h0078);
    repeat (3) @(posedge clk);
    check(ssb[5], 1'b1);
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0078);
    repeat (3) @(posedge clk);
    check(ssb[5], 1'b0);
    $display("test errors done");
    ctrl.fetch();
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0004);
    ctrl.send(sese_pkg::SESE_CMD_EVM_RD, 16'h0000);
    ctrl.send(sese_pkg::SESE_CMD_EVM_WR, 16'h0000);
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0004);
    $display("test query_error done");
    busy <= 1'b1;
    ctrl.send(sese_pkg::SESE_CMD_OPC, 16'h0000);
    repeat (5) @(posedge clk);
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0000);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0001);
    $display("test completion done");
    // a key press while frozen must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    manual <= 1'b1;
    @(posedge clk);
    {ce, manual} <= 2'b10;
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0000);
    ctrl.send(sese_pkg::SESE_CMD_OTHER, 16'h0000);
    q(sese_pkg::SESE_CMD_EVL_RD, 16'h0000);
    $display("test clock_enable done");
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk);
      cond <= 5'h01 << k;
      repeat (2) @(posedge clk);
      q(sese_pkg::SESE_CMD_OPS_COND_RD, 16'h0001 << pos[k]);
    end
    cond <= 5'h00;
    repeat (3) @(posedge clk);
    q(sese_pkg::SESE_CMD_OPS_EV_RD, 16'h0332);
    q(sese_pkg::SESE_CMD_OPS_EV_RD, 16'h0000);
    ctrl.send(sese_pkg::SESE_CMD_OPS_EN_WR, 16'h0010);
    q(sese_pkg::SESE_CMD_OPS_EN_RD, 16'h0010);
    cond <= 5'h02;
    repeat (4) @(posedge clk);
    check(ssb[7], 1'b1);
    q(sese_pkg::SESE_CMD_OPS_EV_RD, 16'h0010);
    repeat (3) @(posedge clk);
    check(ssb[7], 1'b0);
    // falling edge filter only: the end of a measurement is recorded, a new start is not
    ctrl.send(sese_pkg::SESE_CMD_OPS_PTR_WR, 16'h0000);
    ctrl.send(sese_pkg::SESE_CMD_OPS_NTR_WR, 16'h0010);
    cond <= 5'h00;
    repeat (3) @(posedge clk);
    q(sese_pkg::SESE_CMD_OPS_EV_RD, 16'h0010);
    cond <= 5'h02;
    repeat (3) @(posedge clk);
    q(sese_pkg::SESE_CMD_OPS_EV_RD, 16'h0000);
    $display("test operation done");
    tally_and_finish();
  end

  // whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : status_event_reporting_bench
